// ### hdl/smli_exec.sv
// Execution unit for shift, file move, indirect load and literal loads.
// Assumes an Avalon-MM master that holds its request until waitrequest is low.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module smli_exec #(
   parameter int MEM_AW = 12
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o
);

   // Registered state
   logic [7:0]              acc_q, acc_d;
   logic                    carry_q, carry_d;
   logic                    zero_q, zero_d;
   logic [4:0]              bank_q, bank_d;
   logic [6:0]              page_q, page_d;
   logic [15:0]             ptr0_q, ptr0_d;
   logic [15:0]             ptr1_q, ptr1_d;
   logic [15:0]             mem_addr_q, mem_addr_d;
   logic                    wait_q, wait_d;
   logic [31:0]             rdata_q, rdata_d;

   // Data memory
   logic [7:0]              mem [0:(1<<MEM_AW)-1];
   logic                    mem_we;
   logic [MEM_AW-1:0]       mem_wa;
   logic [7:0]              mem_wd;

   // Execution helpers
   logic                    accept;
   smli_pkg::smli_instr_t   instr;
   logic [MEM_AW-1:0]       file_a;
   logic [7:0]              file_v;
   logic [7:0]              result;
   logic [15:0]             ptr_sel_v;
   logic [15:0]             eff_addr;
   logic [15:0]             ptr_new;
   logic [7:0]              load_v;
   logic [31:0]             merged;

   // Byte-lane merge of a write into an old value
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // File address decode, windows redirect through their pointers
   function automatic logic [MEM_AW-1:0] file_addr(input logic [6:0]  f,
                                                   input logic [4:0]  bank,
                                                   input logic [15:0] p0,
                                                   input logic [15:0] p1);
      logic [MEM_AW-1:0] a;
      a = MEM_AW'({bank, f});
      if (f == smli_pkg::WIN0_ADDR) begin
         a = p0[MEM_AW-1:0];
      end else if (f == smli_pkg::WIN1_ADDR) begin
         a = p1[MEM_AW-1:0];
      end
      return a;
   endfunction

   // Pointer step by one, wrapping modulo the full pointer range
   function automatic logic [15:0] ptr_step(input logic [15:0] p,
                                            input logic        down);
      logic [15:0] r;
      r = down ? (p - smli_pkg::PTR_STEP) : (p + smli_pkg::PTR_STEP);
      return r;
   endfunction

   // Sign extension of the relative offset to pointer width
   function automatic logic [15:0] sext_offset(input logic [5:0] o);
      return {{(smli_pkg::PTR_W - smli_pkg::OFFSET_W){o[5]}}, o};
   endfunction

   // Zero flag of a moved or computed byte
   function automatic logic is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction

   // Operand fetch and pointer arithmetic
   always_comb begin
      instr     = smli_pkg::smli_instr_t'(avs_writedata_i);
      file_a    = file_addr(instr.operand[6:0], bank_q, ptr0_q, ptr1_q);
      file_v    = mem[file_a];
      ptr_sel_v = instr.ptr_sel ? ptr1_q : ptr0_q;
      eff_addr  = ptr_sel_v;
      ptr_new   = ptr_sel_v;
      if (instr.op == smli_pkg::SMLI_LOAD_VIA_POINTER_K) begin
         eff_addr = ptr_sel_v + sext_offset(instr.offset);
      end else begin
         unique case (instr.pointer_update_type)
            smli_pkg::SMLI_PRE_INC: begin
               eff_addr = ptr_step(ptr_sel_v, 1'b0);
               ptr_new  = ptr_step(ptr_sel_v, 1'b0);
            end
            smli_pkg::SMLI_PRE_DEC: begin
               eff_addr = ptr_step(ptr_sel_v, 1'b1);
               ptr_new  = ptr_step(ptr_sel_v, 1'b1);
            end
            smli_pkg::SMLI_POST_INC: begin
               ptr_new  = ptr_step(ptr_sel_v, 1'b0);
            end
            smli_pkg::SMLI_POST_DEC: begin
               ptr_new  = ptr_step(ptr_sel_v, 1'b1);
            end
         endcase
      end
      load_v = mem[eff_addr[MEM_AW-1:0]];
   end

   // Bus slave and instruction execution
   always_comb begin
      acc_d      = acc_q;
      carry_d    = carry_q;
      zero_d     = zero_q;
      bank_d     = bank_q;
      page_d     = page_q;
      ptr0_d     = ptr0_q;
      ptr1_d     = ptr1_q;
      mem_addr_d = mem_addr_q;
      rdata_d    = rdata_q;
      mem_we     = 1'b0;
      mem_wa     = file_a;
      mem_wd     = 8'h00;
      result     = 8'h00;
      merged     = 32'h0000_0000;
      accept     = (avs_read_i | avs_write_i) & wait_q;
      wait_d     = ~accept;
      if (accept && avs_read_i) begin
         unique case (avs_address_i)
            smli_pkg::OFF_ACC:      rdata_d = {24'h000000, acc_q};
            smli_pkg::OFF_STATUS:   rdata_d = {30'h0000_0000, zero_q, carry_q};
            smli_pkg::OFF_BANK:     rdata_d = {27'h000_0000, bank_q};
            smli_pkg::OFF_PAGE:     rdata_d = {25'h000_0000, page_q};
            smli_pkg::OFF_PTR0:     rdata_d = {16'h0000, ptr0_q};
            smli_pkg::OFF_PTR1:     rdata_d = {16'h0000, ptr1_q};
            smli_pkg::OFF_MEM_ADDR: rdata_d = {16'h0000, mem_addr_q};
            smli_pkg::OFF_MEM_DATA: rdata_d = {24'h000000, mem[mem_addr_q[MEM_AW-1:0]]};
            default:                rdata_d = 32'h0000_0000;
         endcase
      end
      if (accept && avs_write_i) begin
         unique case (avs_address_i)
            smli_pkg::OFF_INSTR: begin
               unique case (instr.op)
                  smli_pkg::SMLI_SHIFT_RIGHT_LOGICAL: begin
                     result  = {1'b0, file_v[7:1]};
                     carry_d = file_v[0];
                     zero_d  = is_zero(result);
                     if (instr.dest_sel) begin
                        mem_we = 1'b1;
                        mem_wd = result;
                     end else begin
                        acc_d  = result;
                     end
                  end
                  smli_pkg::SMLI_COPY_FILE_REG: begin
                     zero_d = is_zero(file_v);
                     if (instr.dest_sel) begin
                        mem_we = 1'b1;
                        mem_wd = file_v;
                     end else begin
                        acc_d  = file_v;
                     end
                  end
                  smli_pkg::SMLI_LOAD_VIA_POINTER,
                  smli_pkg::SMLI_LOAD_VIA_POINTER_K: begin
                     acc_d  = load_v;
                     zero_d = is_zero(load_v);
                     if (instr.ptr_sel) begin
                        ptr1_d = ptr_new;
                     end else begin
                        ptr0_d = ptr_new;
                     end
                  end
                  smli_pkg::SMLI_LOAD_BANK_LITERAL: begin
                     bank_d = instr.operand[4:0];
                  end
                  smli_pkg::SMLI_LOAD_PAGE_LITERAL: begin
                     page_d = instr.operand[6:0];
                  end
                  smli_pkg::SMLI_LOAD_LITERAL_ACC: begin
                     acc_d = instr.operand;
                  end
                  smli_pkg::SMLI_OP_NOP: begin
                     acc_d = acc_q;
                  end
               endcase
            end
            smli_pkg::OFF_ACC: begin
               merged = be_merge({24'h000000, acc_q}, avs_writedata_i, avs_byteenable_i);
               acc_d  = merged[7:0];
            end
            smli_pkg::OFF_STATUS: begin
               merged  = be_merge({30'h0000_0000, zero_q, carry_q}, avs_writedata_i,
                                  avs_byteenable_i);
               carry_d = merged[smli_pkg::STAT_C_BIT];
               zero_d  = merged[smli_pkg::STAT_Z_BIT];
            end
            smli_pkg::OFF_BANK: begin
               merged = be_merge({27'h000_0000, bank_q}, avs_writedata_i, avs_byteenable_i);
               bank_d = merged[4:0];
            end
            smli_pkg::OFF_PAGE: begin
               merged = be_merge({25'h000_0000, page_q}, avs_writedata_i, avs_byteenable_i);
               page_d = merged[6:0];
            end
            smli_pkg::OFF_PTR0: begin
               merged = be_merge({16'h0000, ptr0_q}, avs_writedata_i, avs_byteenable_i);
               ptr0_d = merged[15:0];
            end
            smli_pkg::OFF_PTR1: begin
               merged = be_merge({16'h0000, ptr1_q}, avs_writedata_i, avs_byteenable_i);
               ptr1_d = merged[15:0];
            end
            smli_pkg::OFF_MEM_ADDR: begin
               merged     = be_merge({16'h0000, mem_addr_q}, avs_writedata_i, avs_byteenable_i);
               mem_addr_d = merged[15:0];
            end
            smli_pkg::OFF_MEM_DATA: begin
               mem_we = avs_byteenable_i[0];
               mem_wa = mem_addr_q[MEM_AW-1:0];
               mem_wd = avs_writedata_i[7:0];
            end
            default: begin
               merged = 32'h0000_0000;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q      <= smli_pkg::ACC_RST;
         carry_q    <= smli_pkg::FLAG_RST;
         zero_q     <= smli_pkg::FLAG_RST;
         bank_q     <= smli_pkg::BANK_RST;
         page_q     <= smli_pkg::PAGE_RST;
         ptr0_q     <= smli_pkg::PTR_RST;
         ptr1_q     <= smli_pkg::PTR_RST;
         mem_addr_q <= smli_pkg::PTR_RST;
         wait_q     <= 1'b1;
         rdata_q    <= 32'h0000_0000;
      end else begin
         acc_q      <= acc_d;
         carry_q    <= carry_d;
         zero_q     <= zero_d;
         bank_q     <= bank_d;
         page_q     <= page_d;
         ptr0_q     <= ptr0_d;
         ptr1_q     <= ptr1_d;
         mem_addr_q <= mem_addr_d;
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
      end
   end

   // Data memory write port
   always_ff @(posedge clock_i) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;

endmodule

`default_nettype wire

// ### pkg/smli_pkg.sv
// Package for the shift, move and literal-load execution block.
// Assumes a 32-bit Avalon-MM slave with a byte address and a single core clock.
package smli_pkg;

   // Bus geometry
   localparam int          BUS_AW       = 8;
   localparam int          BUS_DW       = 32;
   localparam int          BUS_BE_W     = 4;

   // Register byte offsets
   localparam logic [7:0]  OFF_INSTR    = 8'h00;
   localparam logic [7:0]  OFF_ACC      = 8'h04;
   localparam logic [7:0]  OFF_STATUS   = 8'h08;
   localparam logic [7:0]  OFF_BANK     = 8'h0c;
   localparam logic [7:0]  OFF_PAGE     = 8'h10;
   localparam logic [7:0]  OFF_PTR0     = 8'h14;
   localparam logic [7:0]  OFF_PTR1     = 8'h18;
   localparam logic [7:0]  OFF_MEM_ADDR = 8'h1c;
   localparam logic [7:0]  OFF_MEM_DATA = 8'h20;

   // Field widths and positions
   localparam int          ACC_W        = 8;
   localparam int          BANK_W       = 5;
   localparam int          PAGE_W       = 7;
   localparam int          PTR_W        = 16;
   localparam int          FILE_W       = 7;
   localparam int          OFFSET_W     = 6;
   localparam int          STAT_C_BIT   = 0;
   localparam int          STAT_Z_BIT   = 1;

   // Indirect window file addresses
   localparam logic [6:0]  WIN0_ADDR    = 7'h00;
   localparam logic [6:0]  WIN1_ADDR    = 7'h01;

   // Reset values
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic [4:0]  BANK_RST     = 5'h00;
   localparam logic [6:0]  PAGE_RST     = 7'h00;
   localparam logic [15:0] PTR_RST      = 16'h0000;
   localparam logic        FLAG_RST     = 1'b0;

   // Pointer steps
   localparam logic [15:0] PTR_STEP     = 16'h0001;

   // Instruction operations
   typedef enum logic [2:0] {
      SMLI_OP_NOP              = 3'h0,
      SMLI_SHIFT_RIGHT_LOGICAL = 3'h1,
      SMLI_COPY_FILE_REG       = 3'h2,
      SMLI_LOAD_VIA_POINTER    = 3'h3,
      SMLI_LOAD_VIA_POINTER_K  = 3'h4,
      SMLI_LOAD_BANK_LITERAL   = 3'h5,
      SMLI_LOAD_PAGE_LITERAL   = 3'h6,
      SMLI_LOAD_LITERAL_ACC    = 3'h7
   } smli_op_t;

   // Pointer update type
   typedef enum logic [1:0] {
      SMLI_PRE_INC  = 2'b00,
      SMLI_PRE_DEC  = 2'b01,
      SMLI_POST_INC = 2'b10,
      SMLI_POST_DEC = 2'b11
   } smli_ptr_update_t;

   // Instruction word as written to the instruction register
   typedef struct packed {
      logic [10:0]      unused;
      smli_op_t         op;
      logic [5:0]       offset;
      smli_ptr_update_t pointer_update_type;
      logic             ptr_sel;
      logic             dest_sel;
      logic [7:0]       operand;
   } smli_instr_t;

endpackage

// ### dv/smli_exec_properties.sv
// Checker for the execution unit's bus answers and register widths.
// Assumes the smli_exec port list and a single clock domain.
`timescale 1ns/100ps
`default_nettype none

module smli_exec_properties (
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   // Bus
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_take;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence

   sequence s_rd(logic [7:0] a);
      avs_read_i && avs_waitrequest_o && avs_address_i == a;
   endsequence

   a_answer_once: assert property (s_take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("waitrequest not low for exactly one cycle");
   a_idle_wait: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> avs_waitrequest_o) else $error("answer without request");
   a_data_hold: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data moved without a read");
   a_instr_wo: assert property (s_rd(smli_pkg::OFF_INSTR) |=> avs_readdata_o == 32'h0)
      else $error("instruction register readable");
   a_bank_width: assert property (s_rd(smli_pkg::OFF_BANK) |=> avs_readdata_o[31:5] == 27'h0)
      else $error("bank select wider than 5 bits");
   a_page_width: assert property (s_rd(smli_pkg::OFF_PAGE) |=> avs_readdata_o[31:7] == 25'h0)
      else $error("page latch wider than 7 bits");
   a_ptr_width: assert property ((s_rd(smli_pkg::OFF_PTR0) or s_rd(smli_pkg::OFF_PTR1))
      |=> avs_readdata_o[31:16] == 16'h0) else $error("pointer wider than 16 bits");
   a_acc_width: assert property (s_rd(smli_pkg::OFF_ACC) |=> avs_readdata_o[31:8] == 24'h0)
      else $error("working register wider than 8 bits");
   a_flag_width: assert property (s_rd(smli_pkg::OFF_STATUS) |=> avs_readdata_o[31:2] == 30'h0)
      else $error("status wider than 2 bits");
endmodule

bind smli_exec smli_exec_properties u_props (
   .clock_i           (clock_i),
   .rst_n_i           (rst_n_i),
   .avs_address_i     (avs_address_i),
   .avs_read_i        (avs_read_i),
   .avs_write_i       (avs_write_i),
   .avs_readdata_o    (avs_readdata_o),
   .avs_waitrequest_o (avs_waitrequest_o)
);

`default_nettype wire

// ### dv/tb_shift_move_literal_instr_exec.sv
// Self-checking bench for the execution unit.
// Assumes smli_exec with MEM_AW 8 and a 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_shift_move_literal_instr_exec;
   logic        clock_i    = 1'b0;
   logic        rst_n_i    = 1'b0;
   logic [7:0]  adr        = 8'h00;
   logic        rd         = 1'b0;
   logic        wr         = 1'b0;
   logic [31:0] wdat       = 32'h0;
   logic [31:0] rdat;
   logic        wait_o;
   logic [31:0] rdata;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   smli_exec #(.MEM_AW(8)) dut (
      .clock_i           (clock_i),
      .rst_n_i           (rst_n_i),
      .avs_address_i     (adr),
      .avs_read_i        (rd),
      .avs_write_i       (wr),
      .avs_writedata_i   (wdat),
      .avs_byteenable_i  (4'hf),
      .avs_readdata_o    (rdat),
      .avs_waitrequest_o (wait_o)
   );

   initial begin
      forever #4 clock_i = ~clock_i;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr  <= a;
      wr   <= w;
      rd   <= !w;
      wdat <= d;
      do begin
         @(posedge clock_i);
      end while (wait_o !== 1'b0);
      rdata = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      xfer(1'b0, a, 32'h0);
      num_checks++;
      if (rdata !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, rdata);
      end
   endtask

   task automatic mset(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, smli_pkg::OFF_MEM_ADDR, a);
      xfer(1'b1, smli_pkg::OFF_MEM_DATA, d);
   endtask

   task automatic mchk(input logic [31:0] a, input logic [31:0] e, input string nm);
      xfer(1'b1, smli_pkg::OFF_MEM_ADDR, a);
      chk(smli_pkg::OFF_MEM_DATA, e, nm);
   endtask

   task automatic ex(input logic [2:0] op, input logic [7:0] k, input logic d,
                     input logic p, input logic [1:0] m, input logic [5:0] o);
      xfer(1'b1, smli_pkg::OFF_INSTR, {11'h000, op, o, m, p, d, k});
   endtask

   task automatic t_reset();
      chk(smli_pkg::OFF_ACC, 32'h0, "acc reset");
      chk(smli_pkg::OFF_PTR1, 32'h0, "ptr1 reset");
      xfer(1'b1, 8'h3c, 32'hffff_ffff);
      chk(8'h3c, 32'h0, "unmapped");
      chk(smli_pkg::OFF_INSTR, 32'h0, "instr reads zero");
   endtask

   task automatic t_shift();
      mset(32'h10, 32'h81);
      ex(smli_pkg::SMLI_SHIFT_RIGHT_LOGICAL, 8'h10, 1'b0, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_ACC, 32'h40, "shift acc");
      chk(smli_pkg::OFF_STATUS, 32'h1, "shift flags");
      mchk(32'h10, 32'h81, "shift source");
      mset(32'h11, 32'h01);
      ex(smli_pkg::SMLI_SHIFT_RIGHT_LOGICAL, 8'h11, 1'b1, 1'b0, 2'b00, 6'h00);
      mchk(32'h11, 32'h0, "shift file");
      chk(smli_pkg::OFF_STATUS, 32'h3, "shift zero");
      chk(smli_pkg::OFF_ACC, 32'h40, "shift acc kept");
   endtask

   task automatic t_copy();
      mset(32'h20, 32'h7e);
      ex(smli_pkg::SMLI_COPY_FILE_REG, 8'h20, 1'b1, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_STATUS, 32'h1, "copy self flags");
      chk(smli_pkg::OFF_ACC, 32'h40, "copy self acc");
      mchk(32'h20, 32'h7e, "copy self file");
      mset(32'h21, 32'h0);
      ex(smli_pkg::SMLI_COPY_FILE_REG, 8'h21, 1'b0, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_ACC, 32'h0, "copy acc");
      chk(smli_pkg::OFF_STATUS, 32'h3, "copy zero");
      xfer(1'b1, smli_pkg::OFF_PTR1, 32'h30);
      mset(32'h30, 32'h9a);
      ex(smli_pkg::SMLI_COPY_FILE_REG, 8'h01, 1'b0, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_ACC, 32'h9a, "window");
   endtask

   task automatic t_modes();
      logic [31:0] dat [4] = '{32'h33, 32'h11, 32'h22, 32'h22};
      logic [31:0] pa  [4] = '{32'h41, 32'h3f, 32'h41, 32'h3f};
      mset(32'h3f, 32'h11);
      mset(32'h40, 32'h22);
      mset(32'h41, 32'h33);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, smli_pkg::OFF_PTR0, 32'h40);
         xfer(1'b1, smli_pkg::OFF_STATUS, 32'h1);
         ex(smli_pkg::SMLI_LOAD_VIA_POINTER, 8'h00, 1'b0, 1'b0, i[1:0], 6'h00);
         chk(smli_pkg::OFF_ACC, dat[i], "ptr data");
         chk(smli_pkg::OFF_PTR0, pa[i], "ptr after");
         chk(smli_pkg::OFF_STATUS, 32'h1, "ptr flags");
      end
   endtask

   task automatic t_offset();
      xfer(1'b1, smli_pkg::OFF_PTR1, 32'h60);
      ex(smli_pkg::SMLI_LOAD_VIA_POINTER_K, 8'h00, 1'b0, 1'b1, 2'b00, 6'h20);
      chk(smli_pkg::OFF_ACC, 32'h22, "offset low");
      mset(32'h7f, 32'h0);
      ex(smli_pkg::SMLI_LOAD_VIA_POINTER_K, 8'h00, 1'b0, 1'b1, 2'b00, 6'h1f);
      chk(smli_pkg::OFF_STATUS, 32'h3, "offset zero");
      chk(smli_pkg::OFF_PTR1, 32'h60, "offset ptr");
   endtask

   task automatic t_wrap();
      xfer(1'b1, smli_pkg::OFF_PTR0, 32'hffff);
      mset(32'hff, 32'h5c);
      ex(smli_pkg::SMLI_LOAD_VIA_POINTER, 8'h00, 1'b0, 1'b0, 2'b10, 6'h00);
      chk(smli_pkg::OFF_PTR0, 32'h0, "wrap up");
      ex(smli_pkg::SMLI_LOAD_VIA_POINTER, 8'h00, 1'b0, 1'b0, 2'b01, 6'h00);
      chk(smli_pkg::OFF_PTR0, 32'hffff, "wrap down");
      chk(smli_pkg::OFF_ACC, 32'h5c, "wrap data");
   endtask

   task automatic t_literals();
      xfer(1'b1, smli_pkg::OFF_STATUS, 32'h3);
      ex(smli_pkg::SMLI_LOAD_BANK_LITERAL, 8'hff, 1'b0, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_BANK, 32'h1f, "bank");
      ex(smli_pkg::SMLI_LOAD_PAGE_LITERAL, 8'hff, 1'b0, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_PAGE, 32'h7f, "page");
      ex(smli_pkg::SMLI_LOAD_LITERAL_ACC, 8'ha5, 1'b0, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_ACC, 32'ha5, "acc literal");
      ex(smli_pkg::SMLI_OP_NOP, 8'h5a, 1'b1, 1'b0, 2'b00, 6'h00);
      chk(smli_pkg::OFF_ACC, 32'ha5, "nop acc");
      chk(smli_pkg::OFF_STATUS, 32'h3, "literal flags");
   endtask

   task tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_shift();
      t_copy();
      t_modes();
      t_offset();
      t_wrap();
      t_literals();
      tally_and_finish();
   end
endmodule

`default_nettype wire
